//--- core/ddc_front_end.sv
/*
 per-channel front end: input format, level detector, carrier
 oscillator, quadrature mixer, pseudo-noise addition, output buffer.
 assumes converter samples are synchronous to clk; config is static
 while sampling except the oscillator frequency path.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_front_end
   import ddc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ddc_pkg::IN_W-1:0] dataBus0,
   input wire logic [ddc_pkg::IN_W-1:0] dataBus1,
   input wire logic extraExpPin,
   input wire logic input_valid_strobe_n,
   input wire logic [3:0] formatSel,
   input wire logic complexMode,
   input wire logic qTwoClocks,
   input wire logic levelSrcSel,
   input wire logic [3:0] levelFmtSel,
   input wire logic [1:0] levelMode,
   input wire logic [1:0] leakySel,
   input wire logic levelContinuous,
   input wire logic [ddc_pkg::INTV_W-1:0] levelInterval,
   output logic [ddc_pkg::ACC_W-1:0] levelResult,
   output logic levelDone,
   input wire logic [ddc_pkg::FREQ_W-1:0] freqHoldWr,
   input wire logic freqHoldWe,
   input wire logic freqTrigWr,
   input wire logic sync_pulse_in,
   input wire logic syncLoadEn,
   input wire logic zeroPhaseOnLoad,
   input wire logic serialOffsetEn,
   input wire logic [ddc_pkg::PN_W-1:0] pnScale,
   input wire logic [1:0] pnLenSel,
   output logic firstIntegEn,
   output logic laterStageEn,
   output logic mixValid,
   input wire logic mixReady,
   output logic [2*ddc_pkg::OUT_W-1:0] mixData
);
   typedef struct packed {
      logic signed [IN_W-1:0] m;
      logic [EXP_W-1:0] e;
   } ddc_fmt_t;
   // map pins to mantissa and exponent for a format code
   function automatic ddc_fmt_t mapFmt(input logic [3:0] f,
      input logic [IN_W-1:0] x, input logic xn1);
      ddc_fmt_t r;
      r.m = x;
      r.e = 3'h0;
      if (f == FMT_M11) begin
         r.m = {x[15:5], 5'h00};
         r.e = {x[2] | xn1, x[1:0]};
      end else if (f == FMT_M12) begin
         r.m = {x[15:4], 4'h0};
         r.e = {x[2] | xn1, x[1:0]};
      end else if (f == FMT_M13) begin
         r.m = {x[15:3], 3'h0};
         r.e = {x[2] | xn1, x[1:0]};
      end else if (f == FMT_M15) begin
         r.m = {x[15:1], 1'b0};
         r.e = {1'b0, xn1, x[0]};
      end else if (f == FMT_M16) begin
         r.m = x;
         r.e = {2'h0, xn1};
      end
      mapFmt = r;
   endfunction
   // 6 dB per exponent step is a left shift by one
   function automatic logic signed [OUT_W-1:0] applyExp(input ddc_fmt_t v);
      applyExp = OUT_W'(signed'({{(OUT_W-IN_W){v.m[IN_W-1]}}, v.m})
         <<< v.e);
   endfunction
   logic strobe;
   assign strobe = !input_valid_strobe_n;
   ddc_fmt_t mainFmt, lvlFmt;
   assign mainFmt = mapFmt(formatSel, dataBus0, extraExpPin);
   assign lvlFmt = mapFmt(levelFmtSel, levelSrcSel ? dataBus1 : dataBus0,
      extraExpPin);
   logic signed [OUT_W-1:0] sample;
   assign sample = applyExp(mainFmt);

   // complex sequencing
   ddc_cx_state_t cx_q, cx_d;
   logic isQ;
   always_comb begin
      cx_d = cx_q;
      isQ = 1'b0;
      case (cx_q)
         CX_IDLE: begin
            if (complexMode && strobe) begin
               cx_d = qTwoClocks ? CX_WAIT : CX_Q;
            end
         end
         CX_WAIT: cx_d = CX_Q;
         CX_Q: begin
            isQ = 1'b1;
            cx_d = CX_IDLE;
         end
         default: cx_d = CX_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         cx_q <= CX_IDLE;
      end else begin
         cx_q <= cx_d;
      end
   end
   logic isI;
   assign isI = strobe && cx_q == CX_IDLE;

   // carrier oscillator with double-buffered frequency
   logic [FREQ_W-1:0] freqHold_q, freqHold_d, freqAct_q, freqAct_d;
   logic [FREQ_W-1:0] phase_q, phase_d, offset_q, offset_d;
   logic loadFreq;
   assign loadFreq = freqTrigWr || (syncLoadEn && sync_pulse_in);
   always_comb begin
      freqHold_d = freqHoldWe ? freqHoldWr : freqHold_q;
      freqAct_d = loadFreq ? freqHold_q : freqAct_q;
      // serial offset shifts in on bit 0 when bus idle in real mode
      offset_d = offset_q;
      if (serialOffsetEn && !strobe && !complexMode) begin
         offset_d = {offset_q[FREQ_W-2:0], dataBus0[0]};
      end
      if (loadFreq && zeroPhaseOnLoad) begin
         phase_d = '0;
      end else begin
         phase_d = phase_q + freqAct_q + (serialOffsetEn ? offset_q : '0);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         freqHold_q <= '0;
         freqAct_q <= '0;
         phase_q <= '0;
         offset_q <= '0;
      end else begin
         freqHold_q <= freqHold_d;
         freqAct_q <= freqAct_d;
         phase_q <= phase_d;
         offset_q <= offset_d;
      end
   end
   logic signed [AMP_W-1:0] sinV, cosV;
   ddc_sincos_rom u_rom (
      .clk(clk),
      .phase(phase_q[FREQ_W-1 -: PHASE_W]),
      .sinOut(sinV),
      .cosOut(cosV)
   );

   // mixer; sample held while sine/cosine read register settles
   logic signed [OUT_W-1:0] smp_q;
   logic smpI_q, smpQ_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         smp_q <= '0;
         smpI_q <= 1'b0;
         smpQ_q <= 1'b0;
      end else begin
         smp_q <= sample;
         smpI_q <= complexMode ? isI : strobe;
         smpQ_q <= complexMode && isQ;
      end
   end
   logic signed [OUT_W+AMP_W-1:0] pA, pB;
   logic signed [OUT_W-1:0] mixI, mixQ;
   always_comb begin
      if (smpQ_q) begin
         // Q cycle: I path takes Q*-sin, Q path takes Q*cos
         pA = -(smp_q * sinV);
         pB = smp_q * cosV;
      end else begin
         pA = smp_q * cosV;
         pB = smp_q * sinV;
      end
      mixI = pA[OUT_W+AMP_W-2 -: OUT_W];
      mixQ = pB[OUT_W+AMP_W-2 -: OUT_W];
   end
   assign firstIntegEn = smpI_q || smpQ_q;
   assign laterStageEn = smpI_q;

   // pseudo-noise: two lfsrs, product length when both xor'ed
   logic [14:0] l15_q, l15_d;
   logic [22:0] l23_q, l23_d;
   logic [PN_Q_OFFSET-1:0] dly_q, dly_d;
   logic chipI, chipQ;
   always_comb begin
      l15_d = {l15_q[13:0], l15_q[14] ^ l15_q[13]};
      l23_d = {l23_q[21:0], l23_q[22] ^ l23_q[17]};
      case (pnLenSel)
         2'h0: chipI = l15_q[14];
         2'h1: chipI = l23_q[22];
         default: chipI = l15_q[14] ^ l23_q[22];
      endcase
      dly_d = {dly_q[PN_Q_OFFSET-2:0], chipI};
      chipQ = dly_q[PN_Q_OFFSET-1];
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         l15_q <= LFSR15_SEED[14:0];
         l23_q <= LFSR23_SEED[22:0];
         dly_q <= '0;
      end else begin
         l15_q <= l15_d;
         l23_q <= l23_d;
         dly_q <= dly_d;
      end
   end
   // scale sits under three sign bits (quarter scale)
   function automatic logic signed [OUT_W-1:0] pnVal(input logic chip,
      input logic [PN_W-1:0] g);
      logic signed [OUT_W-1:0] mag;
      mag = OUT_W'({3'h0, g, 5'h00});
      pnVal = chip ? -mag : mag;
   endfunction
   logic [2*OUT_W-1:0] bufIn;
   always_comb begin
      if (pnScale == '0) begin
         bufIn = {mixI, mixQ};
      end else begin
         bufIn = {mixI + pnVal(chipI, pnScale), mixQ + pnVal(chipQ, pnScale)};
      end
   end
   logic bufInReady;
   ddc_skid_buf #(.W(2*OUT_W)) u_buf (
      .clk(clk),
      .srst(srst),
      .inValid(smpI_q || smpQ_q),
      .inReady(bufInReady),
      .inData(bufIn),
      .outValid(mixValid),
      .outReady(mixReady),
      .outData(mixData)
   );

   // level detector
   logic [ACC_W-1:0] acc_q, acc_d, res_q, res_d;
   logic [INTV_W:0] cnt_q, cnt_d;
   logic done_q, done_d;
   logic lvlTake;
   logic [ACC_W-1:0] mag;
   logic signed [OUT_W-1:0] lvlS;
   assign lvlS = applyExp(lvlFmt);
   assign mag = ACC_W'(lvlS[OUT_W-1] ? -lvlS : lvlS);
   // only I samples in complex mode
   assign lvlTake = complexMode ? isI : strobe;
   always_comb begin
      logic [ACC_W-1:0] leak;
      logic last;
      leak = '0;
      last = 1'b0;
      acc_d = acc_q;
      res_d = res_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      case (leakySel)
         2'h0: leak = mag;
         2'h1: leak = acc_q - (acc_q >> 8) + (mag >> 8);
         2'h2: leak = acc_q - (acc_q >> 12) + (mag >> 12);
         default: leak = acc_q - (acc_q >> 16) + (mag >> 16);
      endcase
      last = cnt_q >= ({1'b0, levelInterval} + 17'h00001);
      if (lvlTake) begin
         case (levelMode)
            2'h0: acc_d = acc_q + mag;
            2'h1: acc_d = (mag > acc_q) ? mag : acc_q;
            default: acc_d = leak;
         endcase
         cnt_d = cnt_q + 17'h00001;
         if (levelContinuous && levelMode != 2'h0) begin
            res_d = acc_d;
            cnt_d = '0;
         end else if (last) begin
            res_d = acc_d;
            done_d = 1'b1;
            cnt_d = '0;
            acc_d = '0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         acc_q <= '0;
         res_q <= '0;
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         res_q <= res_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end
   assign levelResult = res_q;
   assign levelDone = done_q;

   // Q one or two clocks after I
   AST_Q_SPACING: assert property (@(posedge clk) disable iff (srst)
      (complexMode && isI && !qTwoClocks) |=> isQ)
      else $error("Q not taken one clock after I");
   AST_Q_TWO: assert property (@(posedge clk) disable iff (srst)
      (complexMode && isI && qTwoClocks) |=> !isQ ##1 isQ)
      else $error("Q not taken two clocks after I");
   AST_LATER_EN: assert property (@(posedge clk) disable iff (srst)
      smpQ_q |-> firstIntegEn && !laterStageEn)
      else $error("later stages enabled on Q cycle");
   AST_OFFSET_SHIFT: assert property (@(posedge clk) disable iff (srst)
      (serialOffsetEn && !strobe && !complexMode)
      |=> offset_q[0] == $past(dataBus0[0]))
      else $error("serial offset bit not shifted in");
   AST_FREQ_LOAD: assert property (@(posedge clk) disable iff (srst)
      freqTrigWr |=> freqAct_q == $past(freqHold_q))
      else $error("active frequency not loaded");
   AST_PHASE_ZERO: assert property (@(posedge clk) disable iff (srst)
      (freqTrigWr && zeroPhaseOnLoad) |=> phase_q == '0)
      else $error("phase not zeroed on load");
   AST_PN_OFF: assert property (@(posedge clk) disable iff (srst)
      pnScale == '0 |-> bufIn == {mixI, mixQ})
      else $error("noise added with zero scale");
   AST_LVL_I_ONLY: assert property (@(posedge clk) disable iff (srst)
      (complexMode && isQ && !lvlTake) |=> cnt_q == $past(cnt_q))
      else $error("level detector took a Q sample");
   AST_REAL_BOTH: assert property (@(posedge clk) disable iff (srst)
      (!complexMode && strobe) |=> firstIntegEn && laterStageEn)
      else $error("real sample not mixed in one cycle");
   AST_BUF_READY: assert property (@(posedge clk) disable iff (srst)
      !bufInReady |-> !mixReady || mixValid)
      else $error("buffer full without stall");
endmodule // ddc_front_end
`default_nettype wire

//--- core/ddc_sincos_rom.sv
/*
 coarse sine/cosine table, registered read data, 256 phase steps,
 quantised to 19-bit amplitude.
 assumes phase arrives one cycle before the value is needed.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_sincos_rom
   import ddc_pkg::*;
(
   input wire logic clk,
   input wire logic [ddc_pkg::PHASE_W-1:0] phase,
   output logic signed [ddc_pkg::AMP_W-1:0] sinOut,
   output logic signed [ddc_pkg::AMP_W-1:0] cosOut
);
   // coarse 8-bit phase index; fine phase bits are dropped to keep area,
   // and phase zero gives an exact zero sine
   function automatic logic signed [AMP_W-1:0] qsin(input logic [7:0] p);
      qsin = AMP_W'(int'($sin(real'(p) * 3.14159265 / 128.0)
         * 131071.0));
   endfunction
   logic signed [AMP_W-1:0] sin_q, cos_q;
   logic [7:0] pTop;
   assign pTop = phase[PHASE_W-1 -: 8];
   always_ff @(posedge clk) begin
      sin_q <= qsin(pTop);
      cos_q <= qsin(pTop + 8'h40);
   end
   assign sinOut = sin_q;
   assign cosOut = cos_q;
endmodule // ddc_sincos_rom

//--- core/ddc_skid_buf.sv
/*
 two-entry buffer with valid/ready on both sides for mixed output words.
 assumes the consumer may hold ready low for any number of cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_skid_buf #(
   parameter int W = 48
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   logic [W-1:0] mem0_q, mem0_d, mem1_q, mem1_d;
   logic [1:0] cnt_q, cnt_d;
   assign inReady = (cnt_q != 2'h2);
   assign outValid = (cnt_q != 2'h0);
   assign outData = mem0_q;
   always_comb begin
      logic push, pop;
      push = inValid && inReady;
      pop = outValid && outReady;
      mem0_d = mem0_q;
      mem1_d = mem1_q;
      cnt_d = cnt_q;
      if (pop) begin
         mem0_d = mem1_q;
      end
      if (push) begin
         if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
            mem0_d = inData;
         end else begin
            mem1_d = inData;
         end
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 2'h0;
         mem0_q <= '0;
         mem1_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         mem0_q <= mem0_d;
         mem1_q <= mem1_d;
      end
   end
   AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (srst)
      cnt_q != 2'h3) else $error("buffer count out of range");
endmodule // ddc_skid_buf

//--- pkg/ddc_pkg.sv
/*
 package for the downconverter front end: format codes, widths, constants.
 assumes a single 100 MHz clock and synchronous active-high reset.
*/
`default_nettype none
package ddc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int IN_W = 16;
   localparam int EXP_W = 3;
   localparam int FREQ_W = 32;
   localparam int PHASE_W = 24;
   localparam int AMP_W = 19;
   localparam int ACC_W = 32;
   localparam int PN_W = 16;
   localparam int INTV_W = 16;
   localparam int OUT_W = 24;
   // input format selector {bit17,bit16,bit8,bit7}
   localparam logic [3:0] FMT_FIX16 = 4'h0;
   localparam logic [3:0] FMT_M11 = 4'h8;
   localparam logic [3:0] FMT_M12 = 4'h9;
   localparam logic [3:0] FMT_M13 = 4'hA;
   localparam logic [3:0] FMT_M15 = 4'hC;
   localparam logic [3:0] FMT_M16 = 4'hD;
   localparam int DB_PER_STEP = 6;
   localparam logic [31:0] LFSR15_SEED = 32'h0000_0001;
   localparam logic [31:0] LFSR23_SEED = 32'h0000_0001;
   localparam int PN_Q_OFFSET = 7;
   typedef enum logic [1:0] {LVL_INTEG, LVL_PEAK, LVL_LEAKY} ddc_lvl_mode_t;
   typedef enum logic [1:0] {PN_LEN15, PN_LEN23, PN_LENPROD} ddc_pn_len_t;
   typedef enum {CX_IDLE, CX_WAIT, CX_Q} ddc_cx_state_t;
endpackage
`default_nettype wire

//--- tb/ddc_adc_model.sv
/*
 converter model: drives both sample buses, extra exponent pin, strobe.
 assumes the bench calls drv once per falling edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_adc_model (
   input wire logic clk,
   output logic [15:0] bus0,
   output logic [15:0] bus1,
   output logic xm,
   output logic stbN
);
   initial begin
      bus0 = 16'h0000;
      bus1 = 16'h0000;
      xm = 1'h0;
      stbN = 1'h1;
   end
   // s: 0 idle, 1 I or real word, 2 Q word
   task automatic drv(input logic [15:0] a, input logic [15:0] b,
      input logic x, input int s);
      stbN = (s != 1);
      // idle bus inverts so a stale word never looks valid
      bus0 = (s == 0) ? ~bus0 : a;
      bus1 = (s == 0) ? ~bus1 : b;
      xm = (s == 1) ? x : xm;
      @(negedge clk);
   endtask
endmodule // ddc_adc_model
`default_nettype wire

//--- tb/test_ddc_front_end.sv
/*
 bench for the front end: level rows, mixer timing, buffer stall,
 oscillator loading and noise. assumes ddc_adc_model as the source.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ddc_front_end;
   import ddc_pkg::*;
   typedef struct {
      logic [3:0] f;
      logic s;
      logic [1:0] m;
      logic x;
      logic [15:0] a;
      logic [15:0] b;
   } ddc_lrow_t;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic [15:0] bus0;
   logic [15:0] bus1;
   logic xm;
   logic stbN;
   logic [3:0] fmt = FMT_FIX16;
   logic cx = 1'h0;
   logic q2 = 1'h0;
   logic src = 1'h0;
   logic [1:0] mode = 2'h0;
   logic [15:0] intv = 16'h0000;
   logic [31:0] lvl;
   logic done;
   logic [31:0] fw = 32'h00000000;
   logic fwe = 1'h0;
   logic ftr = 1'h0;
   logic syn = 1'h0;
   logic synEn = 1'h0;
   logic zp = 1'h0;
   logic [15:0] pns = 16'h0000;
   logic [1:0] pnl = 2'h0;
   logic fi;
   logic li;
   logic mv;
   logic rdy = 1'h1;
   logic [47:0] md;
   logic [47:0] held;
   logic [4:0] fiH = 5'h00;
   logic [4:0] liH = 5'h00;
   logic [4:0] mvH = 5'h00;
   logic anyI = 1'h0;
   logic anyQ = 1'h0;
   logic anyD = 1'h0;
   int wc = 0;
   int dc = 0;
   int failCount = 0;
   int checksDone = 0;
   logic [4:0] fe [3] = '{5'h10, 5'h18, 5'h14};
   ddc_lrow_t rows [6] = '{
      '{FMT_FIX16, 1'h1, 2'h0, 1'h0, 16'h1234, 16'h0100},
      '{FMT_M11, 1'h0, 2'h1, 1'h0, 16'h1207, 16'h0100},
      '{FMT_M12, 1'h1, 2'h1, 1'h1, 16'h2003, 16'h0000},
      '{FMT_M13, 1'h1, 2'h2, 1'h0, 16'h0100, 16'h4ABA},
      '{FMT_M15, 1'h0, 2'h0, 1'h1, 16'h3FFF, 16'h0001},
      '{FMT_M16, 1'h1, 2'h1, 1'h1, 16'h7FFF, 16'h0002}};

   ddc_adc_model ddc_adc_model_inst (.clk(clk), .bus0(bus0), .bus1(bus1),
      .xm(xm), .stbN(stbN));
   ddc_front_end ddc_front_end_inst (.clk(clk), .srst(srst),
      .dataBus0(bus0), .dataBus1(bus1), .extraExpPin(xm),
      .input_valid_strobe_n(stbN), .formatSel(fmt), .complexMode(cx),
      .qTwoClocks(q2), .levelSrcSel(src), .levelFmtSel(fmt),
      .levelMode(mode), .leakySel(2'h0), .levelContinuous(1'h0),
      .levelInterval(intv), .levelResult(lvl), .levelDone(done),
      .freqHoldWr(fw), .freqHoldWe(fwe), .freqTrigWr(ftr),
      .sync_pulse_in(syn), .syncLoadEn(synEn), .zeroPhaseOnLoad(zp),
      .serialOffsetEn(1'h0), .pnScale(pns), .pnLenSel(pnl),
      .firstIntegEn(fi), .laterStageEn(li), .mixValid(mv),
      .mixReady(rdy), .mixData(md));

   always #5 clk = ~clk;

   // sampled on the rising edge, where the design itself samples
   always @(posedge clk) begin
      fiH <= {fiH[3:0], fi};
      liH <= {liH[3:0], li};
      mvH <= {mvH[3:0], mv};
      dc <= dc + int'(done);
      if (mv && rdy) begin
         wc <= wc + 1;
         anyI <= anyI | (|md[47:24]);
         anyQ <= anyQ | (|md[23:0]);
         anyD <= anyD | (md[47:24] != md[23:0]);
      end
   end

   task automatic check(input string n, input logic [47:0] seen,
      input logic [47:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic [31:0] mapv(input logic [3:0] f,
      input logic [15:0] d, input logic x);
      logic [15:0] m;
      logic [2:0] e;
      m = d;
      e = 3'h0;
      case (f)
         FMT_M11, FMT_M12, FMT_M13: begin
            m = d & 16'hFFF8;
            e = {d[2] | x, d[1], d[0]};
         end
         FMT_M15: begin
            m = d & 16'hFFFE;
            e = {1'h0, x, d[0]};
         end
         FMT_M16: e = {2'h0, x};
         default: e = 3'h0;
      endcase
      return {16'h0000, m} << e;
   endfunction

   function automatic logic [31:0] comb(input ddc_lrow_t r);
      logic [31:0] p;
      logic [31:0] q;
      p = mapv(r.f, r.a, r.x);
      q = mapv(r.f, r.b, r.x);
      if (r.m == 2'h0)
         return p + q;
      if (r.m == 2'h1)
         return (p > q) ? p : q;
      return q;
   endfunction

   task automatic clr();
      anyI = 1'h0;
      anyQ = 1'h0;
      anyD = 1'h0;
      wc = 0;
      dc = 0;
   endtask

   task automatic rst(input int n);
      srst = 1'h1;
      repeat (n) @(negedge clk);
      srst = 1'h0;
      clr();
   endtask

   task automatic idle(input int n);
      repeat (n) ddc_adc_model_inst.drv(16'h0000, 16'h0000, 1'h0, 0);
   endtask

   task automatic drv1(input logic [15:0] d, input int s);
      ddc_adc_model_inst.drv(d, d, 1'h0, s);
   endtask

   task automatic lv(input logic [15:0] a, input logic x);
      if (src)
         ddc_adc_model_inst.drv(~a, a, x, 1);
      else
         ddc_adc_model_inst.drv(a, ~a, x, 1);
   endtask

   task automatic waitDone();
      int k;
      k = 0;
      while (done !== 1'h1 && dc == 0 && k < 40) begin
         idle(1);
         k++;
      end
      check("levelDone", 48'(done === 1'h1 || dc != 0), 48'h1);
   endtask

   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge clk);
      s = 1'h0;
   endtask

   task automatic burst(input int n, input logic [15:0] d);
      clr();
      repeat (n) drv1(d, 1);
      idle(4);
   endtask

   initial begin
      #50000;
      failCount++;
      print_verdict();
   end

   initial begin
      rst(16);
      check("reset valid", 48'(mv), 48'h0);
      check("reset level", 48'(lvl), 48'h0);
      foreach (rows[i]) begin
         fmt = rows[i].f;
         src = rows[i].s;
         mode = rows[i].m;
         rst(2);
         lv(rows[i].a, rows[i].x);
         lv(rows[i].b, rows[i].x);
         waitDone();
         check("level", 48'(lvl), 48'(comb(rows[i])));
      end
      fmt = FMT_M13;
      src = 1'h0;
      mode = 2'h0;
      intv = 16'h0003;
      rst(2);
      repeat (4) lv(16'h7FFF, 1'h1);
      check("early done", 48'(dc), 48'h0);
      lv(16'h7FFF, 1'h1);
      waitDone();
      check("long sum", 48'(lvl), 48'h13FEC00);
      fmt = FMT_FIX16;
      mode = 2'h1;
      intv = 16'h0000;
      cx = 1'h1;
      rst(2);
      for (int k = 1; k < 3; k++) begin
         drv1(16'(k << 8), 1);
         drv1(16'h7000, 2);
      end
      waitDone();
      check("complex level", 48'(lvl), 48'h200);
      for (int j = 0; j < 3; j++) begin
         cx = (j > 0);
         q2 = (j == 2);
         rst(2);
         drv1(16'h1000, 1);
         if (j == 2)
            idle(1);
         if (j > 0)
            drv1(16'h1000, 2);
         idle(4 - j);
         @(posedge clk);
         #1;
         check("first integ", 48'(fiH), 48'(fe[j]));
         check("later stage", 48'(liH), 48'h10);
         if (j == 0)
            check("mix valid", 48'(mvH), 48'h08);
         @(negedge clk);
      end
      cx = 1'h0;
      rdy = 1'h0;
      rst(2);
      for (int k = 0; k < 3; k++)
         drv1(16'((k + 1) << 12), 1);
      idle(3);
      check("stall valid", 48'(mv), 48'h1);
      held = md;
      idle(3);
      check("held word", md, held);
      rdy = 1'h1;
      clr();
      idle(6);
      check("words out", 48'(wc), 48'h2);
      check("drained", 48'(mv), 48'h0);
      rst(2);
      burst(4, 16'h4000);
      check("q at phase 0", 48'(anyQ), 48'h0);
      check("i live", 48'(anyI), 48'h1);
      fw = 32'h10000000;
      pulse(fwe);
      burst(4, 16'h4000);
      check("hold only", 48'(anyQ), 48'h0);
      pulse(syn);
      burst(4, 16'h4000);
      check("sync off", 48'(anyQ), 48'h0);
      pulse(ftr);
      burst(8, 16'h4000);
      check("trigger load", 48'(anyQ), 48'h1);
      zp = 1'h1;
      synEn = 1'h1;
      fw = 32'h00000000;
      pulse(fwe);
      pulse(syn);
      burst(2, 16'h4000);
      burst(4, 16'h4000);
      check("phase zeroed", 48'(anyQ), 48'h0);
      rst(2);
      burst(6, 16'h0000);
      check("no noise", 48'({anyI, anyQ}), 48'h0);
      for (int p = 0; p < 3; p++) begin
         pnl = 2'(p);
         pns = 16'h4000;
         rst(2);
         burst(40, 16'h0000);
         check("noise i/q", 48'({anyI, anyD}), 48'h3);
      end
      print_verdict();
   end
endmodule // test_ddc_front_end
`default_nettype wire
